/* peripheral_pin_remap.v */
/*
 * Peripheral pin remap configuration register, bits 31 to 8, on a classic
 * Wishbone slave, with registered routing selects to the pin multiplexers.
 * Assumes one clock, synchronous active-high reset, byte-lane writes through sel_i.
 */
// Function
// - Bit 29 routes USB start-of-frame to timer1 trigger 1 input
// - Bit 28 moves third serial port pins to full remap set
// - Bits 26:24 write-only debug config: both, no reset pin, two-wire, none
// - Bit 22 moves second CAN receive and transmit to alternate pins
// - Bit 20 picks second converter trigger: irq line eleven or timer seven
// - Bit 18 picks first converter trigger: irq line eleven or timer seven
// - Bit 16 feeds timer4 channel 3 from pin or low-speed oscillator
// - Bit 15 reuses crystal pins as port D bits 0 and 1
// - Bits 14:13 first CAN pins: default, unused, partial, full
// - Bit 12 moves four timer3 channels from port B to port D
// - Bits 11:10 timer2 pins: default, unused, partial, full on port C
// - Bits 9:8 timer1 pins: default, partial, unused, full
// - Register at offset 0x04, resets to all zeros
`timescale 1ns/1ps
`default_nettype none
`include "remap_defs.vh"

module peripheral_pin_remap (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [3:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output reg         err_o,
    output reg         t1_trig1_sof_select_o,
    output reg         third_serial_port_pin_select_o,
    output reg         boundary_debug_port_en_o,
    output reg         debug_test_reset_pin_en_o,
    output reg         two_wire_debug_port_en_o,
    output reg         second_can_pin_select_o,
    output reg         second_converter_trigger_select_o,
    output reg         first_converter_trigger_select_o,
    output reg         t4_ch3_input_select_o,
    output reg         osc_pins_as_port_bits_o,
    output reg  [1:0]  first_can_pin_select_o,
    output reg         first_can_partial_o,
    output reg         first_can_full_o,
    output reg         t3_channel_pin_select_o,
    output reg  [1:0]  t2_channel_pin_select_o,
    output reg         t2_partial_o,
    output reg         t2_full_o,
    output reg  [1:0]  t1_channel_pin_select_o,
    output reg         t1_partial_o,
    output reg         t1_full_o
);

    // ------------------------------------------------------------------
    // Byte-lane write merge
    // ------------------------------------------------------------------
    function [31:0] lane_merge;
        input [31:0] old_value;
        input [31:0] new_value;
        input [3:0]  lanes;
        integer      i;
        begin
            lane_merge = old_value;
            for (i = 0; i < 4; i = i + 1) begin
                if (lanes[i]) begin
                    lane_merge[8*i +: 8] = new_value[8*i +: 8];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    reg  [31:0] remap_cfg;
    wire        req;
    wire        hit;
    wire        wr_hit;
    wire [31:0] merged;
    wire        boundary_en;
    wire        test_rst_en;
    wire        two_wire_en;
    wire        can1_part;
    wire        can1_full;
    wire        t2_part;
    wire        t2_fl;
    wire        t1_part;
    wire        t1_fl;

    // New request only when no answer is outstanding: ack drops next cycle
    assign req    = cyc_i & stb_i & ~ack_o & ~err_o;
    assign hit    = (adr_i == `REMAP_CFG_OFFSET);
    assign wr_hit = req & hit & we_i;
    assign merged = lane_merge(remap_cfg, dat_i, sel_i);

    // ------------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------------
    // Reserved bits are never stored, so they stay zero whatever is written
    always @(posedge clk_i) begin
        if (rst_i) begin
            remap_cfg <= `REMAP_CFG_RESET;
        end else if (wr_hit) begin
            remap_cfg <= merged & (`REMAP_RW_MASK | `REMAP_WO_MASK);
        end
    end

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------
    // Debug field is write-only: it reads back as zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= req & hit;
            err_o <= req & ~hit;
            if (req & hit & ~we_i) begin
                dat_o <= remap_cfg & `REMAP_RW_MASK;
            end else begin
                dat_o <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Field decoders
    // ------------------------------------------------------------------
    debug_port_decode u_dbg (
        .code_i        (remap_cfg[`DBG_HI:`DBG_LO]),
        .boundary_en_o (boundary_en),
        .test_rst_en_o (test_rst_en),
        .two_wire_en_o (two_wire_en)
    );

    two_bit_remap_decode #(.PARTIAL_CODE(`SEL_CODE_10)) u_can1 (
        .code_i        (remap_cfg[`CAN1ST_HI:`CAN1ST_LO]),
        .sel_default_o (),
        .sel_partial_o (can1_part),
        .sel_full_o    (can1_full)
    );

    two_bit_remap_decode #(.PARTIAL_CODE(`SEL_CODE_10)) u_t2 (
        .code_i        (remap_cfg[`T2_HI:`T2_LO]),
        .sel_default_o (),
        .sel_partial_o (t2_part),
        .sel_full_o    (t2_fl)
    );

    two_bit_remap_decode #(.PARTIAL_CODE(`SEL_CODE_01)) u_t1 (
        .code_i        (remap_cfg[`T1_HI:`T1_LO]),
        .sel_default_o (),
        .sel_partial_o (t1_part),
        .sel_full_o    (t1_fl)
    );

    // ------------------------------------------------------------------
    // Registered routing selects
    // ------------------------------------------------------------------
    // One register stage keeps outputs glitch-free; selects follow the
    // stored value one cycle after it is written
    always @(posedge clk_i) begin
        if (rst_i) begin
            t1_trig1_sof_select_o             <= 1'b0;
            third_serial_port_pin_select_o    <= 1'b0;
            boundary_debug_port_en_o          <= 1'b1;
            debug_test_reset_pin_en_o         <= 1'b1;
            two_wire_debug_port_en_o          <= 1'b1;
            second_can_pin_select_o           <= 1'b0;
            second_converter_trigger_select_o <= 1'b0;
            first_converter_trigger_select_o  <= 1'b0;
            t4_ch3_input_select_o             <= 1'b0;
            osc_pins_as_port_bits_o           <= 1'b0;
            first_can_pin_select_o            <= `SEL_DEFAULT;
            first_can_partial_o               <= 1'b0;
            first_can_full_o                  <= 1'b0;
            t3_channel_pin_select_o           <= 1'b0;
            t2_channel_pin_select_o           <= `SEL_DEFAULT;
            t2_partial_o                      <= 1'b0;
            t2_full_o                         <= 1'b0;
            t1_channel_pin_select_o           <= `SEL_DEFAULT;
            t1_partial_o                      <= 1'b0;
            t1_full_o                         <= 1'b0;
        end else begin
            t1_trig1_sof_select_o <= remap_cfg[`T1_TRIG1_SOF_BIT];
            third_serial_port_pin_select_o <= remap_cfg[`SPI3RD_BIT];
            boundary_debug_port_en_o  <= boundary_en;
            debug_test_reset_pin_en_o <= test_rst_en;
            two_wire_debug_port_en_o  <= two_wire_en;
            second_can_pin_select_o <= remap_cfg[`CAN2ND_BIT];
            second_converter_trigger_select_o <= remap_cfg[`ADC2ND_BIT];
            first_converter_trigger_select_o <= remap_cfg[`ADC1ST_BIT];
            t4_ch3_input_select_o   <= remap_cfg[`T4CH3_BIT];
            osc_pins_as_port_bits_o <= remap_cfg[`OSCPINS_BIT];
            first_can_pin_select_o <= remap_cfg[`CAN1ST_HI:`CAN1ST_LO];
            first_can_partial_o     <= can1_part;
            first_can_full_o        <= can1_full;
            t3_channel_pin_select_o <= remap_cfg[`T3_BIT];
            t2_channel_pin_select_o <= remap_cfg[`T2_HI:`T2_LO];
            t2_partial_o            <= t2_part;
            t2_full_o               <= t2_fl;
            t1_channel_pin_select_o <= remap_cfg[`T1_HI:`T1_LO];
            t1_partial_o            <= t1_part;
            t1_full_o               <= t1_fl;
        end
    end

endmodule // peripheral_pin_remap
`default_nettype wire

/* remap_defs.vh */
/*
 * Constants for the peripheral pin remap configuration block: register
 * offset, field positions, reset values and field encodings.
 * Assumes inclusion by bare name from every design file that needs it.
 */
`ifndef REMAP_DEFS_VH
`define REMAP_DEFS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REMAP_CFG_OFFSET     4'h4
`define REMAP_CFG_RESET      32'h00000000
`define REMAP_RW_MASK        32'h3055FF00
`define REMAP_WO_MASK        32'h07000000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define T1_TRIG1_SOF_BIT     29
`define SPI3RD_BIT           28
`define DBG_HI               26
`define DBG_LO               24
`define CAN2ND_BIT           22
`define ADC2ND_BIT           20
`define ADC1ST_BIT           18
`define T4CH3_BIT            16
`define OSCPINS_BIT          15
`define CAN1ST_HI            14
`define CAN1ST_LO            13
`define T3_BIT               12
`define T2_HI                11
`define T2_LO                10
`define T1_HI                9
`define T1_LO                8

// ----------------------------------------------------------------------
// Debug port configuration codes
// ----------------------------------------------------------------------
`define DBG_BOTH             3'h0
`define DBG_BOTH_NO_RST      3'h1
`define DBG_TWO_WIRE         3'h2
`define DBG_NONE             3'h4

// ----------------------------------------------------------------------
// Two-bit remap codes
// ----------------------------------------------------------------------
`define SEL_DEFAULT          2'h0
`define SEL_CODE_01          2'h1
`define SEL_CODE_10          2'h2
`define SEL_FULL             2'h3

`endif

/* debug_port_decode.v */
/*
 * Decodes the write-only debug configuration field into port enables.
 * Assumes the code comes from a register; output is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "remap_defs.vh"

module debug_port_decode (
    input  wire [2:0] code_i,
    output reg        boundary_en_o,
    output reg        test_rst_en_o,
    output reg        two_wire_en_o
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Undefined codes fall back to the reset behaviour: both ports on
    always @* begin
        case (code_i)
            `DBG_BOTH_NO_RST: begin
                boundary_en_o = 1'b1;
                test_rst_en_o = 1'b0;
                two_wire_en_o = 1'b1;
            end
            `DBG_TWO_WIRE: begin
                boundary_en_o = 1'b0;
                test_rst_en_o = 1'b0;
                two_wire_en_o = 1'b1;
            end
            `DBG_NONE: begin
                boundary_en_o = 1'b0;
                test_rst_en_o = 1'b0;
                two_wire_en_o = 1'b0;
            end
            default: begin
                boundary_en_o = 1'b1;
                test_rst_en_o = 1'b1;
                two_wire_en_o = 1'b1;
            end
        endcase
    end

endmodule // debug_port_decode
`default_nettype wire

/* two_bit_remap_decode.v */
/*
 * Decodes a two-bit remap field into default/partial/full one-hot selects.
 * Assumes the partial code is given per instance; the unused code maps
 * to the default pins.
 */
`timescale 1ns/1ps
`default_nettype none
`include "remap_defs.vh"

module two_bit_remap_decode #(
    parameter [1:0] PARTIAL_CODE = `SEL_CODE_10
) (
    input  wire [1:0] code_i,
    output wire       sel_default_o,
    output wire       sel_partial_o,
    output wire       sel_full_o
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Unused code keeps the pins at their default so no pin is orphaned
    assign sel_full_o    = (code_i == `SEL_FULL);
    assign sel_partial_o = (code_i == PARTIAL_CODE);
    assign sel_default_o = ~sel_full_o & ~sel_partial_o;

endmodule // two_bit_remap_decode
`default_nettype wire

/* peripheral_pin_remap_asserts.sv */
/* Checker for the pin remap register: bus answer, reset state, field
   decodes and when the selects move. Assumes binding to the top module. */
`timescale 1ns/1ps
`default_nettype none
`include "remap_defs.vh"

module remap_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [3:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        err_o,
    input wire logic        t1_trig1_sof_select_o,
    input wire logic        boundary_debug_port_en_o,
    input wire logic        debug_test_reset_pin_en_o,
    input wire logic        two_wire_debug_port_en_o,
    input wire logic [1:0]  first_can_pin_select_o,
    input wire logic        first_can_partial_o,
    input wire logic        first_can_full_o,
    input wire logic [1:0]  t2_channel_pin_select_o,
    input wire logic        t2_partial_o,
    input wire logic        t2_full_o,
    input wire logic [1:0]  t1_channel_pin_select_o,
    input wire logic        t1_partial_o,
    input wire logic        t1_full_o
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Undefined codes fall back to the reset pattern
    function automatic logic [2:0] dbg_en(input logic [2:0] c);
        case (c)
            `DBG_BOTH_NO_RST: dbg_en = 3'h5;
            `DBG_TWO_WIRE:    dbg_en = 3'h1;
            `DBG_NONE:        dbg_en = 3'h0;
            default:          dbg_en = 3'h7;
        endcase
    endfunction

    wire logic [2:0] dbg = {boundary_debug_port_en_o,
        debug_test_reset_pin_en_o, two_wire_debug_port_en_o};
    sequence s_take;
        cyc_i && stb_i && !ack_o && !err_o;
    endsequence
    sequence s_wr(lane);
        ack_o && we_i && lane;
    endsequence

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_ACK_ONCE: assert property (s_take ##0 adr_i == `REMAP_CFG_OFFSET
        |=> ack_o && !err_o ##1 !ack_o) else $error("ack not one cycle");
    AST_ERR_UNMAPPED: assert property (s_take ##0 adr_i != 4'h4
        |=> err_o && !ack_o && dat_o == 32'h0) else $error("no err");
    AST_RESET_STATE: assert property ($fell(rst_i) |-> !ack_o && !err_o
        && dat_o == 32'h0 && dbg == 3'h7 && !t1_trig1_sof_select_o)
        else $error("bad reset state");
    AST_SOF_SEL: assert property (s_wr(sel_i[3])
        |=> t1_trig1_sof_select_o == $past(dat_i[29])) else $error("sof");
    AST_DBG_DECODE: assert property (s_wr(sel_i[3])
        |=> dbg == dbg_en($past(dat_i[26:24]))) else $error("debug decode");
    AST_CAN1_DECODE: assert property (s_wr(sel_i[1])
        |=> first_can_pin_select_o == $past(dat_i[14:13])
        && first_can_partial_o == (first_can_pin_select_o == 2'h2)
        && first_can_full_o == (first_can_pin_select_o == 2'h3))
        else $error("first can decode");
    AST_T2_DECODE: assert property (s_wr(sel_i[1])
        |=> t2_channel_pin_select_o == $past(dat_i[11:10])
        && t2_partial_o == (t2_channel_pin_select_o == 2'h2)
        && t2_full_o == (t2_channel_pin_select_o == 2'h3))
        else $error("timer2 decode");
    AST_T1_DECODE: assert property (s_wr(sel_i[1])
        |=> t1_channel_pin_select_o == $past(dat_i[9:8])
        && t1_partial_o == (t1_channel_pin_select_o == 2'h1)
        && t1_full_o == (t1_channel_pin_select_o == 2'h3))
        else $error("timer1 decode");
    AST_HOLD: assert property (!(ack_o && we_i) |=> $stable({dbg,
        t1_trig1_sof_select_o, first_can_pin_select_o,
        t2_channel_pin_select_o, t1_channel_pin_select_o}))
        else $error("select moved without write");
endmodule // remap_checker

bind peripheral_pin_remap remap_checker remap_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .t1_trig1_sof_select_o(t1_trig1_sof_select_o),
    .boundary_debug_port_en_o(boundary_debug_port_en_o),
    .debug_test_reset_pin_en_o(debug_test_reset_pin_en_o),
    .two_wire_debug_port_en_o(two_wire_debug_port_en_o),
    .first_can_pin_select_o(first_can_pin_select_o),
    .first_can_partial_o(first_can_partial_o),
    .first_can_full_o(first_can_full_o),
    .t2_channel_pin_select_o(t2_channel_pin_select_o),
    .t2_partial_o(t2_partial_o), .t2_full_o(t2_full_o),
    .t1_channel_pin_select_o(t1_channel_pin_select_o),
    .t1_partial_o(t1_partial_o), .t1_full_o(t1_full_o));
`default_nettype wire

/* peripheral_pin_remap_tb.sv */
/* Self-checking bench: Wishbone master tasks, a reference model of the
   register and a comparison of every select after each access.
   Assumes the design files and remap_defs.vh are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "remap_defs.vh"

module peripheral_pin_remap_tb;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i;
    logic [3:0]  adr_i, sel_i, rs;
    logic [31:0] dat_i, model, fd;
    wire  [31:0] dat_o;
    wire         ack_o, err_o;
    wire  [22:0] sv;
    logic [2:0]  dbg;
    int          n_mismatch, num_checks, seed, cycles;
    logic [2:0]  legal_dbg [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    // Stored bits: 29, 28, 22, 20, 18, 16 and 15:8; debug field kept apart
    localparam logic [31:0] RW_BITS = 32'h3055FF00;

    peripheral_pin_remap peripheral_pin_remap_inst (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .err_o(err_o), .t1_trig1_sof_select_o(sv[22]),
        .third_serial_port_pin_select_o(sv[21]),
        .boundary_debug_port_en_o(sv[20]),
        .debug_test_reset_pin_en_o(sv[19]),
        .two_wire_debug_port_en_o(sv[18]), .second_can_pin_select_o(sv[17]),
        .second_converter_trigger_select_o(sv[16]),
        .first_converter_trigger_select_o(sv[15]),
        .t4_ch3_input_select_o(sv[14]), .osc_pins_as_port_bits_o(sv[13]),
        .first_can_pin_select_o(sv[12:11]), .first_can_partial_o(sv[10]),
        .first_can_full_o(sv[9]), .t3_channel_pin_select_o(sv[8]),
        .t2_channel_pin_select_o(sv[7:6]), .t2_partial_o(sv[5]),
        .t2_full_o(sv[4]), .t1_channel_pin_select_o(sv[3:2]),
        .t1_partial_o(sv[1]), .t1_full_o(sv[0]));

    // ------------------------------------------------------------------
    // Model and checks
    // ------------------------------------------------------------------
    function automatic logic [22:0] exp_sel(input logic [31:0] m,
                                            input logic [2:0] c);
        logic [2:0] e;
        case (c)
            3'h1:    e = 3'h5;
            3'h2:    e = 3'h1;
            3'h4:    e = 3'h0;
            default: e = 3'h7;
        endcase
        return {m[29:28], e, m[22], m[20], m[18], m[16:13],
            m[14:13] == 2'h2, m[14:13] == 2'h3, m[12:10],
            m[11:10] == 2'h2, m[11:10] == 2'h3, m[9:8],
            m[9:8] == 2'h1, m[9:8] == 2'h3};
    endfunction

    task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask

    task automatic chk_sel(input logic [22:0] e);
        num_checks++;
        if (sv !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: exp %h got %h", $time, e, sv);
        end
    endtask

    // Classic single cycle; waits for ack or err, giving up after 16 cycles
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int          n;
        logic [31:0] rd, m;
        logic        ak, er;
        n = 0;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 16);
        rd = dat_o;
        ak = ack_o;
        er = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        chk_word({30'h0, a == 4'h4, a != 4'h4}, {30'h0, ak, er});
        if (a == `REMAP_CFG_OFFSET && w) begin
            model = (model & ~m) | (d & m & RW_BITS);
            if (s[3]) dbg = d[26:24];
        end
        if (!w) chk_word(a == 4'h4 ? model : 32'h0, rd);
        @(posedge clk_i);
        chk_sel(exp_sel(model, dbg));
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Runs take about 440 cycles; over ten times that means a hang
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_sim;
        end
    end

    initial begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = 43'h0;
        rst_i = 1'b1;
        seed = 15024;
        model = `REMAP_CFG_RESET;
        dbg = 3'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h4, 4'hF, 32'h0);
        $display("test reset done");
        foreach (legal_dbg[i]) begin
            fd = {5'h0, legal_dbg[i], 24'h0};
            wb(1'b1, 4'h4, 4'h8, fd);
        end
        for (int c = 0; c < 4; c++) begin
            fd = {17'h0, c[1:0], 1'b0, c[1:0], c[1:0], 8'h0};
            wb(1'b1, 4'h4, 4'h2, fd);
        end
        $display("test field codes done");
        wb(1'b1, 4'h4, 4'hF, 32'hF8FFFFFF);
        wb(1'b0, 4'h4, 4'hF, 32'h0);
        wb(1'b1, 4'h8, 4'hF, 32'h3015FF00);
        wb(1'b0, 4'h0, 4'hF, 32'h0);
        $display("test refused bits done");
        repeat (40) begin
            dat_i <= $random(seed) & RW_BITS;
            @(posedge clk_i);
            rs = 4'($random(seed));
            fd = dat_i | {5'h0, legal_dbg[2'($random(seed))], 24'h0};
            wb(1'b1, 4'h4, rs, fd);
            wb(1'b0, 4'h4, 4'hF, 32'h0);
        end
        $display("test random done");
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        model = `REMAP_CFG_RESET;
        dbg = 3'h0;
        wb(1'b0, 4'h4, 4'hF, 32'h0);
        $display("test second reset done");
        end_sim;
    end
endmodule // peripheral_pin_remap_tb
`default_nettype wire
